// ==== pkg/pfs_regs.vh ====
// constants for the program flow sequencer
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
`define PFS_AW 12
`define PFS_IW 18
`define PFS_STACK_DEPTH 30
`define PFS_DEPTH_W 5
`define PFS_RESET_PC 12'h000
`define PFS_INT_VECTOR 12'hfff
// operation codes in bits 17:12 of the instruction word
`define PFS_OP_HI 17
`define PFS_OP_LO 12
`define PFS_OP_JUMP 6'h22
`define PFS_OP_JUMP_Z 6'h32
`define PFS_OP_JUMP_NZ 6'h36
`define PFS_OP_JUMP_C 6'h3a
`define PFS_OP_JUMP_NC 6'h3e
`define PFS_OP_JUMP_IND 6'h26
`define PFS_OP_CALL 6'h20
`define PFS_OP_CALL_Z 6'h30
`define PFS_OP_CALL_NZ 6'h34
`define PFS_OP_CALL_C 6'h38
`define PFS_OP_CALL_NC 6'h3c
`define PFS_OP_CALL_IND 6'h24
`define PFS_OP_RETURN 6'h25
`define PFS_OP_INTERRUPT_RETURN 6'h29
// register address fields for the indirect forms
`define PFS_RX_HI 11
`define PFS_RX_LO 8
`define PFS_RY_HI 7
`define PFS_RY_LO 4
`endif

// ==== rtl/pfs_sequencer.v ====
// program counter and return-address stack of the 8-bit core
`timescale 1ns/1ps
`include "pfs_regs.vh"

// Contract
// RQ1: conditional jump loads target when its carry or zero condition holds
// RQ2: conditional jump not met just increments program counter
// RQ3: jumps change nothing but the program counter
// RQ4: indirect target is low nibble of high register then low register
// RQ5: indirect jump ignores high nibble, leaves source registers untouched
// RQ6: indirect jump always taken, same time for every target
// RQ7: every instruction takes exactly two clock cycles
// RQ8: jump to itself holds there; reset or interrupt still redirect
// RQ9: jump opcode 22 with target in low twelve bits
// RQ10: dedicated automatic return stack, pushed by calls, popped by returns
// RQ11: stack holds up to 30 entries
// RQ12: interrupt entry uses one stack entry like a call
// RQ13: reset starts at address zero, normal flow increments
// RQ14: return pops last address, adds one, loads program counter
// RQ15: push beyond capacity triggers internal reset
// RQ16: return with empty stack triggers internal reset
// RQ17: depth counter cleared by reset, compared to 30 and zero
module pfs_sequencer (
  // clock and reset
  input wire CLK,
  input wire RESETN,
  input wire CLK_EN,
  // program memory
  output reg [11:0] PROG_ADDR,
  output reg PROG_READ,
  input wire [17:0] INSTRUCTION,
  // core flags and register reads
  input wire CARRY_FLAG,
  input wire ZERO_FLAG,
  output reg [3:0] HIGH_TARGET_SEL,
  output reg [3:0] LOW_TARGET_SEL,
  input wire [7:0] HIGH_TARGET_REGISTER,
  input wire [7:0] LOW_TARGET_REGISTER,
  // interrupt entry request from the core, sampled at execute
  input wire INT_REQ,
  output reg INT_ACK,
  // internal reset request back to the core
  output reg INTERNAL_RESET
);
  localparam [1:0] ST_FETCH = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state_r;
  reg [11:0] pc_r;
  reg [4:0] depth_r;
  reg [11:0] stack_mem [0:`PFS_STACK_DEPTH-1];
  reg [17:0] instr_r;
  reg rst_req_r;
  // stack entries hold the address of the instruction that pushed them

  // condition decode shared by jumps and calls
  function cond_true;
    input [5:0] op;
    input c;
    input z;
    begin
      case (op)
        `PFS_OP_JUMP_Z, `PFS_OP_CALL_Z: cond_true = z;
        `PFS_OP_JUMP_NZ, `PFS_OP_CALL_NZ: cond_true = ~z;
        `PFS_OP_JUMP_C, `PFS_OP_CALL_C: cond_true = c;
        `PFS_OP_JUMP_NC, `PFS_OP_CALL_NC: cond_true = ~c;
        `PFS_OP_JUMP, `PFS_OP_CALL, `PFS_OP_JUMP_IND, `PFS_OP_CALL_IND: cond_true = 1'b1;
        default: cond_true = 1'b0;
      endcase
    end
  endfunction

  // call forms, conditional or not; each pushes its own address when taken
  function is_call_op;
    input [5:0] code;
    begin
      case (code)
        `PFS_OP_CALL: is_call_op = 1'b1;
        `PFS_OP_CALL_Z: is_call_op = 1'b1;
        `PFS_OP_CALL_NZ: is_call_op = 1'b1;
        `PFS_OP_CALL_C: is_call_op = 1'b1;
        `PFS_OP_CALL_NC: is_call_op = 1'b1;
        `PFS_OP_CALL_IND: is_call_op = 1'b1;
        default: is_call_op = 1'b0;
      endcase
    end
  endfunction

  // both returns pop; conditional returns are not decoded
  function is_ret_op;
    input [5:0] code;
    begin
      case (code)
        `PFS_OP_RETURN: is_ret_op = 1'b1;
        `PFS_OP_INTERRUPT_RETURN: is_ret_op = 1'b1;
        default: is_ret_op = 1'b0;
      endcase
    end
  endfunction

  wire [5:0] op = instr_r[`PFS_OP_HI:`PFS_OP_LO];
  wire is_ind = (op == `PFS_OP_JUMP_IND) || (op == `PFS_OP_CALL_IND);
  wire is_call = is_call_op(op);
  wire is_ret = is_ret_op(op);
  wire taken = cond_true(op, CARRY_FLAG, ZERO_FLAG);
  // high nibble of the high register is dropped here
  wire [11:0] ind_target = {HIGH_TARGET_REGISTER[3:0], LOW_TARGET_REGISTER}; // see RQ4 RQ5
  wire [11:0] target = is_ind ? ind_target : instr_r[11:0]; // see RQ9
  // capacity checks kept in one place so the limit cannot drift
  wire stack_full = (depth_r == `PFS_STACK_DEPTH); // see RQ11 RQ17
  wire stack_empty = (depth_r == 5'h00); // see RQ17
  wire [11:0] top = stack_empty ? 12'h000 : stack_mem[depth_r - 5'h01];
  // the popped address points at the pushing instruction, so one is added
  wire [11:0] ret_addr = top + 12'h001; // see RQ14
  // sequential successor, also the result of every branch not taken
  wire [11:0] pc_inc = pc_r + 12'h001;
  wire call_taken = is_call & taken;
  wire push = INT_REQ | call_taken; // see RQ12
  wire overflow = push && stack_full; // see RQ15 RQ17
  wire underflow = !INT_REQ && is_ret && stack_empty; // see RQ16 RQ17
  // either fault abandons the instruction; a restart beats running on with a bad stack
  wire stack_fault = overflow || underflow;

  // limitation: an interrupt pushes the abandoned address and the interrupt
  // return adds one, so the abandoned instruction is skipped; software should
  // let interrupts land on instructions that may be lost
  reg [11:0] pc_nxt;
  always @* begin
    if (INT_REQ) begin
      pc_nxt = `PFS_INT_VECTOR; // see RQ8
    end else if (is_ret) begin
      pc_nxt = ret_addr; // see RQ14
    end else if (taken) begin
      pc_nxt = target; // see RQ1 RQ6
    end else begin
      pc_nxt = pc_inc; // see RQ2 RQ13
    end
  end

  // fetch and execute simply alternate; no path stretches an instruction
  reg [1:0] state_nxt;
  always @* begin
    case (state_r)
      ST_FETCH: state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = ST_FETCH; // see RQ7
      default: state_nxt = ST_FETCH;
    endcase
  end

  // stack depth after the execute cycle; a fault leaves it for the restart to clear
  reg [4:0] depth_nxt;
  always @* begin
    depth_nxt = depth_r;
    if (state_r == ST_EXEC && !stack_fault) begin
      if (push) begin
        depth_nxt = depth_r + 5'h01; // see RQ10 RQ11
      end else if (is_ret) begin
        depth_nxt = depth_r - 5'h01; // see RQ10
      end
    end
  end

  // the stack array has no reset; the depth alone says which entries are valid
  wire stack_we = CLK_EN && !rst_req_r && (state_r == ST_EXEC) && push && !stack_fault;
  always @(posedge CLK) begin
    if (stack_we) begin
      stack_mem[depth_r] <= pc_r; // see RQ10 RQ11 RQ12
    end
  end

  // only the program counter and stack move; flags are inputs, never written (see RQ3)
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_FETCH;
      pc_r <= `PFS_RESET_PC; // see RQ13
      depth_r <= 5'h00; // see RQ17
      instr_r <= 18'h00000;
      rst_req_r <= 1'b0;
      PROG_ADDR <= `PFS_RESET_PC;
      PROG_READ <= 1'b0;
      HIGH_TARGET_SEL <= 4'h0;
      LOW_TARGET_SEL <= 4'h0;
      INT_ACK <= 1'b0;
      INTERNAL_RESET <= 1'b0;
    end else if (CLK_EN) begin
      INT_ACK <= 1'b0;
      INTERNAL_RESET <= 1'b0;
      PROG_READ <= 1'b0;
      if (rst_req_r) begin
        // self reset: restart like a hardware reset, stack emptied
        rst_req_r <= 1'b0;
        state_r <= ST_FETCH;
        pc_r <= `PFS_RESET_PC; // see RQ15 RQ16
        depth_r <= 5'h00;
        PROG_ADDR <= `PFS_RESET_PC;
      end else begin
        case (state_r)
          ST_FETCH: begin
            instr_r <= INSTRUCTION;
            HIGH_TARGET_SEL <= INSTRUCTION[`PFS_RX_HI:`PFS_RX_LO];
            LOW_TARGET_SEL <= INSTRUCTION[`PFS_RY_HI:`PFS_RY_LO];
            state_r <= state_nxt;
          end
          ST_EXEC: begin
            // every path spends one fetch and one execute cycle (see RQ7 RQ6)
            state_r <= state_nxt;
            if (stack_fault) begin
              rst_req_r <= 1'b1;
              INTERNAL_RESET <= 1'b1;
            end else begin
              depth_r <= depth_nxt; // see RQ10
              INT_ACK <= INT_REQ;
              pc_r <= pc_nxt;
              PROG_ADDR <= pc_nxt;
              PROG_READ <= 1'b1;
            end
          end
          default: state_r <= ST_FETCH;
        endcase
      end
    end
  end
endmodule

// ==== dv/pfs_checker.sv ====
// port assertions for the program flow sequencer
`timescale 1ns/1ps
module pfs_checker (
  // clock, reset, program memory, interrupt and internal reset
  input wire CLK, input wire RESETN, input wire [11:0] PROG_ADDR, input wire PROG_READ,
  input wire [17:0] INSTRUCTION, input wire INT_REQ, input wire INT_ACK, input wire INTERNAL_RESET,
  // flags and register data
  input wire CARRY_FLAG, input wire ZERO_FLAG,
  input wire [7:0] HIGH_TARGET_REGISTER, input wire [7:0] LOW_TARGET_REGISTER
);
  wire [5:0] op = INSTRUCTION[17:12];
  wire [11:0] tg = INSTRUCTION[11:0];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // new address out, instruction fetched two edges back, not an interrupt entry
  sequence s_ex;
    PROG_READ && !$past(INT_REQ);
  endsequence
  AST_PULSE: assert property (PROG_READ |=> !PROG_READ) else $error("pulse too long");
  AST_HOLD: assert property ($changed(PROG_ADDR) |-> PROG_READ || $past(INTERNAL_RESET))
    else $error("address moved early");
  AST_JMP: assert property (s_ex ##0 ($past(op, 2) == 6'h22) |-> PROG_ADDR == $past(tg, 2))
    else $error("jump target wrong");
  AST_JZ: assert property (s_ex ##0 ($past(op, 2) == 6'h32) |-> PROG_ADDR ==
    ($past(ZERO_FLAG) ? $past(tg, 2) : $past(PROG_ADDR) + 12'h1)) else $error("zero jump wrong");
  AST_JNC: assert property (s_ex ##0 ($past(op, 2) == 6'h3e) |-> PROG_ADDR ==
    (!$past(CARRY_FLAG) ? $past(tg, 2) : $past(PROG_ADDR) + 12'h1)) else $error("carry jump wrong");
  AST_IND: assert property (s_ex ##0 ($past(op, 2) == 6'h26) |-> PROG_ADDR ==
    {$past(HIGH_TARGET_REGISTER[3:0]), $past(LOW_TARGET_REGISTER)}) else $error("indirect wrong");
  AST_INC: assert property (s_ex ##0 ($past(op, 2) == 6'h00) |-> PROG_ADDR ==
    $past(PROG_ADDR) + 12'h1) else $error("no increment");
  AST_INT: assert property (PROG_READ && $past(INT_REQ) |-> INT_ACK && PROG_ADDR == 12'hfff)
    else $error("interrupt entry wrong");
  AST_IRST: assert property (INTERNAL_RESET |=> !INTERNAL_RESET && PROG_ADDR == 12'h000)
    else $error("restart wrong");
endmodule
bind pfs_sequencer pfs_checker u_chk (.*);

// ==== dv/pfs_prog_mem.sv ====
// program memory model answering the sequencer's address
`timescale 1ns/1ps
module pfs_prog_mem (
  // address in, word out
  input wire [11:0] addr,
  output wire [17:0] word
);
  // unwritten words read as unknown so a stray fetch shows up
  logic [17:0] mem [0:4095];
  assign word = mem[addr];
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the program flow sequencer
`timescale 1ns/1ps
module testbench;
  reg CLK = 0, RESETN = 0, CLK_EN = 1, CARRY_FLAG = 0, ZERO_FLAG = 0, INT_REQ = 0, ir = 0;
  reg [7:0] HIGH_TARGET_REGISTER = 0, LOW_TARGET_REGISTER = 0;
  wire [11:0] PROG_ADDR;
  wire [17:0] INSTRUCTION;
  wire [3:0] HIGH_TARGET_SEL, LOW_TARGET_SEL;
  wire PROG_READ, INT_ACK, INTERNAL_RESET;
  int miscompares = 0, checks = 0, n;
  logic [11:0] pc = 0, q[$];
  logic [31:0] rs = 32'hb2ca, r;
  logic [17:0] w;
  logic [11:0] t;
  logic [5:0] ops [7] = '{6'h22, 6'h26, 6'h32, 6'h36, 6'h3a, 6'h3e, 6'h00};
  pfs_sequencer dut (.*);
  pfs_prog_mem u_mem (.addr(PROG_ADDR), .word(INSTRUCTION));
  initial forever #12.5 CLK = ~CLK;
  always @(posedge CLK) if (INTERNAL_RESET === 1'b1) ir <= 1;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // v packs interrupt, carry, zero, high and low register bytes
  function automatic logic [11:0] nx(input [17:0] w, input [18:0] v);
    case (w[17:12])
      6'h22: return w[11:0];
      6'h26: return v[11:0];
      6'h32, 6'h36: return (v[16] ^ w[14]) ? w[11:0] : pc + 12'h1;
      6'h3a, 6'h3e: return (v[17] ^ w[14]) ? w[11:0] : pc + 12'h1;
      default: return pc + 12'h1;
    endcase
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input [17:0] w, input [18:0] v, input [11:0] e, input x);
    u_mem.mem[pc] = w;
    ir = 0;
    n = 0;
    @(posedge CLK);
    {INT_REQ, CARRY_FLAG, ZERO_FLAG, HIGH_TARGET_REGISTER, LOW_TARGET_REGISTER} <= v;
    do begin
      @(negedge CLK);
      n++;
    end while (PROG_READ !== 1'b1 && n < 20);
    chk(PROG_ADDR, e);
    chk({11'h0, ir}, {11'h0, x});
    if (!x) chk(12'(n), 12'h2);
    if (!x) chk({11'h0, INT_ACK}, {11'h0, v[18]});
    if (!x) chk({4'h0, HIGH_TARGET_SEL, LOW_TARGET_SEL}, {4'h0, w[11:4]});
    pc = e;
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESETN <= 1;
    // restart lands here after every internal reset
    step(18'h22100, 0, 12'h100, 0);
    step(18'h2232c, 0, 12'h32c, 0);
    step(18'h2202b, 0, 12'h02b, 0);
    repeat (2) step({6'h22, pc}, 0, pc, 0);
    // reset in mid-run breaks the hold loop and restarts at zero
    @(posedge CLK);
    RESETN <= 0;
    @(posedge CLK);
    RESETN <= 1;
    pc = 0;
    step(18'h22100, 0, 12'h100, 0);
    // targets kept off address zero and the vector so the restart word survives
    repeat (200) begin
      r = rnd();
      t = r[11:0] & 12'h7ef | 12'h010;
      w = {ops[r[31:29] % 7], t};
      // indirect form: low bits of the word are only selects, the target is in registers
      if (w[17:12] == 6'h26) w[11:0] = r[27:16];
      step(w, {1'b0, r[17:12], t}, nx(w, {1'b0, r[17:12], t}), 0);
    end
    repeat (30) begin
      q.push_back(pc);
      step({6'h20, pc + 12'h10}, 0, pc + 12'h10, 0);
    end
    repeat (30) step(18'h25000, 0, q.pop_back() + 12'h1, 0);
    step(18'h29000, 0, 12'h100, 1);
    q.push_back(pc);
    step({6'h22, pc}, 19'h40000, 12'hfff, 0);
    step(18'h29000, 0, q.pop_back() + 12'h1, 0);
    step({6'h22, pc}, 19'h40000, 12'hfff, 0);
    repeat (29) step({6'h20, pc + 12'h10}, 0, pc + 12'h10, 0);
    step({6'h20, pc + 12'h10}, 0, 12'h100, 1);
    test_done;
  end
endmodule
